/* src/dcld_pkg.sv */
// Constants, field positions and state type for the command block decoder.
// Function
// - Top bit of word 3 picks linear (0) or explicit (1) addressing.
// - Controller memory commands still get words 3 and 4 checked as a sector.
// - Linear mode divides the 31-bit byte address into track, head and sector.
// - Decode covers 77 tracks, two heads, 16 or 26 sectors, 128/256/288 bytes.
// - Linear address has 31 significant bits, range 0 to 7fffffff.
// - Explicit sector numbering starts at 0 for 288-byte sectors, else at 1.
// - Data address is 20 bits: word 6 extension plus word-aligned word 7.
// - Chain bit in word 8 starts the next block at the word 8/9 address.
// - For a power-up load block, words 8/9 give the status return address.
// - Completion interrupts the host at a selectable level, default two.
// - Completion interrupt only when the block's interrupt enable bit is set.
// - An issued completion interrupt sets the occurred bit in word 0.
// - Host call bit raises the controller's level-one local interrupt.
// - A call while busy is ignored; host reads the busy flag first.
// - Word 0 carries the error flag and where the detailed indicator lies.
// - An error stops the chain; interrupt only if that block asked for one.
package dcld_pkg;

    typedef enum logic [2:0] {
        S_IDLE,
        S_FETCH,
        S_CHECK,
        S_DIV,
        S_POST,
        S_EXEC,
        S_DONE
    } dcld_st_t;

    // Word indices inside a command block.
    localparam logic [3:0] IDX_FIRST = 4'h2;
    localparam logic [3:0] IDX_LAST = 4'h9;

    // Bit positions; the block numbers bit 0 as the least significant bit.
    localparam int W0_ERR = 14;
    localparam int W0_IRQ = 13;
    localparam int W0_EXT = 0;
    localparam int W1_PARAM = 8;
    localparam int W2_IE = 7;
    localparam int W3_MODE = 15;
    localparam int W3_HEAD = 8;
    localparam int W8_CHAIN = 15;
    localparam int W_ALIGN = 0;

    // Geometry limits and sizes.
    localparam logic [31:0] MAX_TRK = 32'h0000004c;
    localparam logic [4:0] SPT_26 = 5'h1a;
    localparam logic [4:0] SPT_16 = 5'h10;
    localparam logic [8:0] BPS_128 = 9'h080;
    localparam logic [8:0] BPS_256 = 9'h100;
    localparam logic [8:0] BPS_288 = 9'h120;
    localparam logic [1:0] BPS_SEL_128 = 2'h0;
    localparam logic [1:0] BPS_SEL_256 = 2'h1;
    localparam logic [1:0] BPS_SEL_288 = 2'h2;
    localparam logic [5:0] DIV_LAST = 6'h1f;

    // Controller memory commands.
    localparam logic [7:0] CMD_RD_MEM = 8'h06;
    localparam logic [7:0] CMD_EX_MEM = 8'h08;

    // Reset value of the completion interrupt level.
    localparam logic [3:0] IRQ_LVL_DEF = 4'h2;

endpackage

/* src/dcld_blkmem.sv */
// Sixteen-word command block store with a registered read port.
`timescale 1ns/100ps
`default_nettype none
module dcld_blkmem (
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Write port.
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [15:0] wr_data,
    // Read port.
    input wire logic [3:0] rd_idx,
    output logic [15:0] rd_data
);
    typedef struct packed {
        logic [15:0][15:0] mem;
        logic [15:0] rdata;
    } dcld_mem_t;

    dcld_mem_t s_r;
    dcld_mem_t s_nxt;

    // Read data always lag the index by one cycle.
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = s_r.mem[rd_idx];
        if (wr_en) begin
            s_nxt.mem[wr_idx] = wr_data;
        end
    end

    // Registers.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_data = s_r.rdata;
endmodule
`default_nettype wire

/* src/dcld_decoder.sv */
// Command block decoder with host call and completion interrupt handling.
`timescale 1ns/100ps
`default_nettype none
module dcld_decoder (
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Command block loading.
    input wire logic blk_wr,
    input wire logic [3:0] blk_idx,
    input wire logic [15:0] blk_data,
    input wire logic blk_start,
    input wire logic boot_load,
    input wire logic [7:0] cmd_code,
    // Drive geometry.
    input wire logic cfg_two_sides,
    input wire logic cfg_sec26,
    input wire logic [1:0] cfg_bps_sel,
    input wire logic [3:0] irq_level_sel,
    // Host control port pins.
    input wire logic host_call_bit,
    input wire logic irq_enable_bit,
    // Local processor side.
    output logic controller_call_irq_n,
    output logic busy,
    input wire logic op_done,
    input wire logic op_error,
    // Decoded transfer.
    output logic dec_valid,
    output logic [6:0] dec_track,
    output logic dec_head,
    output logic [4:0] dec_sector,
    output logic [15:0] dec_count,
    output logic [19:0] dec_data_addr,
    output logic mem_cmd,
    // Completion.
    output logic status_wr,
    output logic [15:0] status_w0,
    output logic [15:0] status_w1,
    output logic host_irq,
    output logic [3:0] host_irq_level,
    output logic chain_go,
    output logic [19:0] link_addr,
    output logic link_is_status
);
    typedef struct packed {
        dcld_pkg::dcld_st_t st;
        logic [3:0] ridx;
        logic [3:0] cidx;
        logic rv;
        logic [7:0][15:0] wd;
        logic [31:0] num;
        logic [9:0] rem;
        logic [8:0] den;
        logic [5:0] dcnt;
        logic [1:0] ph;
        logic [6:0] trk;
        logic head;
        logic [4:0] sec;
        logic perr;
        logic oerr;
        logic boot;
        logic [2:0] call_s;
        logic [2:0] ie_s;
        logic armed;
        logic call_irq;
        logic dec_valid;
        logic status_wr;
        logic host_irq;
        logic chain_go;
        logic [15:0] sw0;
        logic [15:0] sw1;
        logic [3:0] lvl;
    } dcld_dec_t;

    dcld_dec_t s_r;
    dcld_dec_t s_nxt;
    logic [15:0] rd_data;
    logic [15:0] w2, w3, w4, w5, w6, w7, w8, w9;
    logic [8:0] nb;
    logic [4:0] ns;
    logic [5:0] nsh;
    logic [9:0] div_sh;
    logic div_ge;
    logic [9:0] div_rem;
    logic call_rise;
    logic ie_rise;
    logic sec_base;
    logic [4:0] sec_raw;
    logic irq_go;
    logic err_all;

    // Block words are read back one at a time, so the store stays a RAM.
    dcld_blkmem u_dcld_blkmem (
        .clock(clock),
        .resetn(resetn),
        .wr_en(blk_wr),
        .wr_idx(blk_idx),
        .wr_data(blk_data),
        .rd_idx(s_r.ridx),
        .rd_data(rd_data)
    );

    // Named views of the captured words.
    assign w2 = s_r.wd[0];
    assign w3 = s_r.wd[1];
    assign w4 = s_r.wd[2];
    assign w5 = s_r.wd[3];
    assign w6 = s_r.wd[4];
    assign w7 = s_r.wd[5];
    assign w8 = s_r.wd[6];
    assign w9 = s_r.wd[7];

    // Geometry from the drive settings.
    always_comb begin
        case (cfg_bps_sel)
            dcld_pkg::BPS_SEL_128: nb = dcld_pkg::BPS_128;
            dcld_pkg::BPS_SEL_256: nb = dcld_pkg::BPS_256;
            default: nb = dcld_pkg::BPS_288;
        endcase
    end
    assign ns = cfg_sec26 ? dcld_pkg::SPT_26 : dcld_pkg::SPT_16;
    assign nsh = cfg_two_sides ? {ns, 1'b0} : {1'b0, ns};

    // One restoring divider step; it is shared by all four divisions.
    assign div_sh = {s_r.rem[8:0], s_r.num[31]};
    assign div_ge = div_sh >= {1'b0, s_r.den};
    assign div_rem = div_ge ? div_sh - {1'b0, s_r.den} : div_sh;

    // Edges seen only after the second synchroniser stage.
    assign call_rise = s_r.call_s[1] & ~s_r.call_s[2];
    assign ie_rise = s_r.ie_s[1] & ~s_r.ie_s[2];

    // Explicit sectors count from zero only for the 288-byte format.
    assign sec_base = (cfg_bps_sel != dcld_pkg::BPS_SEL_288);
    assign sec_raw = w4[4:0];

    // Completion decisions.
    assign err_all = s_r.perr | s_r.oerr;
    assign irq_go = w2[dcld_pkg::W2_IE] & s_r.armed;

    always_comb begin
        s_nxt = s_r;
        s_nxt.dec_valid = 1'b0;
        s_nxt.status_wr = 1'b0;
        s_nxt.host_irq = 1'b0;
        s_nxt.chain_go = 1'b0;
        s_nxt.call_irq = 1'b0;
        s_nxt.call_s = {s_r.call_s[1:0], host_call_bit};
        s_nxt.ie_s = {s_r.ie_s[1:0], irq_enable_bit};
        // A call is honoured only while the decoder is idle.
        if (call_rise && s_r.st == dcld_pkg::S_IDLE) begin
            s_nxt.call_irq = 1'b1;
        end
        case (s_r.st)
            dcld_pkg::S_IDLE: begin
                if (blk_start) begin
                    s_nxt.st = dcld_pkg::S_FETCH;
                    s_nxt.ridx = dcld_pkg::IDX_FIRST;
                    s_nxt.rv = 1'b0;
                    s_nxt.boot = boot_load;
                    s_nxt.perr = 1'b0;
                    s_nxt.oerr = 1'b0;
                end
            end
            dcld_pkg::S_FETCH: begin
                s_nxt.ridx = s_r.ridx + 4'h1;
                s_nxt.cidx = s_r.ridx;
                s_nxt.rv = 1'b1;
                if (s_r.rv) begin
                    s_nxt.wd[3'(s_r.cidx - dcld_pkg::IDX_FIRST)] = rd_data;
                    if (s_r.cidx == dcld_pkg::IDX_LAST) begin
                        s_nxt.st = dcld_pkg::S_CHECK;
                    end
                end
            end
            dcld_pkg::S_CHECK: begin
                // Odd count or unaligned host words are refused up front.
                s_nxt.perr = w5[dcld_pkg::W_ALIGN] | w7[dcld_pkg::W_ALIGN];
                if (w8[dcld_pkg::W8_CHAIN] && w9[dcld_pkg::W_ALIGN] && !s_r.boot) begin
                    s_nxt.perr = 1'b1;
                end
                s_nxt.rem = '0;
                s_nxt.dcnt = '0;
                s_nxt.den = nb;
                s_nxt.st = dcld_pkg::S_DIV;
                // Memory commands go through the same sector check.
                if (!w3[dcld_pkg::W3_MODE]) begin
                    s_nxt.num = {1'b0, w3[14:0], w4};
                    s_nxt.ph = 2'h0;
                end else begin
                    s_nxt.trk = w3[6:0];
                    s_nxt.head = w3[dcld_pkg::W3_HEAD];
                    s_nxt.sec = sec_raw - {4'h0, sec_base};
                    if ({25'h0, w3[6:0]} > dcld_pkg::MAX_TRK) begin
                        s_nxt.perr = 1'b1;
                    end
                    if (w3[dcld_pkg::W3_HEAD] && !cfg_two_sides) begin
                        s_nxt.perr = 1'b1;
                    end
                    if (sec_raw < {4'h0, sec_base}) begin
                        s_nxt.perr = 1'b1;
                    end
                    if (sec_raw - {4'h0, sec_base} >= ns) begin
                        s_nxt.perr = 1'b1;
                    end
                    s_nxt.num = {16'h0000, w5};
                    s_nxt.ph = 2'h3;
                end
            end
            dcld_pkg::S_DIV: begin
                s_nxt.rem = div_rem;
                s_nxt.num = {s_r.num[30:0], div_ge};
                s_nxt.dcnt = s_r.dcnt + 6'h01;
                if (s_r.dcnt == dcld_pkg::DIV_LAST) begin
                    s_nxt.st = dcld_pkg::S_POST;
                end
            end
            dcld_pkg::S_POST: begin
                s_nxt.rem = '0;
                s_nxt.dcnt = '0;
                s_nxt.st = dcld_pkg::S_DIV;
                case (s_r.ph)
                    2'h0: begin
                        // Byte address to sector index, then split by cylinder.
                        if (s_r.rem != 10'h000) begin
                            s_nxt.perr = 1'b1;
                        end
                        s_nxt.den = {3'h0, nsh};
                        s_nxt.ph = 2'h1;
                    end
                    2'h1: begin
                        s_nxt.trk = s_r.num[6:0];
                        if (s_r.num > dcld_pkg::MAX_TRK) begin
                            s_nxt.perr = 1'b1;
                        end
                        s_nxt.num = {22'h000000, s_r.rem};
                        s_nxt.den = {4'h0, ns};
                        s_nxt.ph = 2'h2;
                    end
                    2'h2: begin
                        s_nxt.head = s_r.num[0];
                        s_nxt.sec = s_r.rem[4:0];
                        s_nxt.num = {16'h0000, w5};
                        s_nxt.den = nb;
                        s_nxt.ph = 2'h3;
                    end
                    default: begin
                        if (s_r.rem != 10'h000) begin
                            s_nxt.perr = 1'b1;
                        end
                        // A parameter error skips the transfer entirely.
                        if (s_r.perr || s_r.rem != 10'h000) begin
                            s_nxt.st = dcld_pkg::S_DONE;
                        end else begin
                            s_nxt.dec_valid = 1'b1;
                            s_nxt.st = dcld_pkg::S_EXEC;
                        end
                    end
                endcase
            end
            dcld_pkg::S_EXEC: begin
                if (op_done) begin
                    s_nxt.oerr = op_error;
                    s_nxt.st = dcld_pkg::S_DONE;
                end
            end
            dcld_pkg::S_DONE: begin
                s_nxt.sw0 = '0;
                s_nxt.sw1 = '0;
                s_nxt.sw0[dcld_pkg::W0_ERR] = err_all;
                s_nxt.sw0[dcld_pkg::W0_EXT] = s_r.perr;
                s_nxt.sw1[dcld_pkg::W1_PARAM] = s_r.perr;
                s_nxt.sw0[dcld_pkg::W0_IRQ] = irq_go;
                s_nxt.status_wr = 1'b1;
                s_nxt.host_irq = irq_go;
                if (irq_go) begin
                    s_nxt.armed = 1'b0;
                end
                // The chain ends on any error, and never runs from a load block.
                s_nxt.chain_go = w8[dcld_pkg::W8_CHAIN] & ~err_all & ~s_r.boot;
                s_nxt.lvl = irq_level_sel;
                s_nxt.st = dcld_pkg::S_IDLE;
            end
            default: begin
                s_nxt.st = dcld_pkg::S_IDLE;
            end
        endcase
        // Arming after the clear lets a same-cycle rising edge win.
        if (ie_rise) begin
            s_nxt.armed = 1'b1;
        end
    end

    // Registers.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            s_r <= '0;
            s_r.st <= dcld_pkg::S_IDLE;
            s_r.lvl <= dcld_pkg::IRQ_LVL_DEF;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs.
    assign controller_call_irq_n = ~s_r.call_irq;
    assign busy = (s_r.st != dcld_pkg::S_IDLE);
    assign dec_valid = s_r.dec_valid;
    assign dec_track = s_r.trk;
    assign dec_head = s_r.head;
    assign dec_sector = s_r.sec;
    assign dec_count = w5;
    assign dec_data_addr = {w6[3:0], w7};
    assign mem_cmd = (cmd_code >= dcld_pkg::CMD_RD_MEM) && (cmd_code <= dcld_pkg::CMD_EX_MEM);
    assign status_wr = s_r.status_wr;
    assign status_w0 = s_r.sw0;
    assign status_w1 = s_r.sw1;
    assign host_irq = s_r.host_irq;
    assign host_irq_level = s_r.lvl;
    assign chain_go = s_r.chain_go;
    assign link_addr = {w8[3:0], w9};
    assign link_is_status = s_r.boot;

    // Steps of a completion that interrupts the host.
    sequence s_done_irq;
        s_r.st == dcld_pkg::S_DONE && irq_go && !ie_rise;
    endsequence
    sequence s_irq_out;
        host_irq && status_w0[dcld_pkg::W0_IRQ] && !s_r.armed;
    endsequence

    a_call_idle: assert property (@(posedge clock) disable iff (!resetn)
        call_rise && !busy |=> !controller_call_irq_n ##1 controller_call_irq_n)
        else $error("Call while idle did not pulse the local interrupt.");

    a_call_busy: assert property (@(posedge clock) disable iff (!resetn)
        call_rise && busy |=> controller_call_irq_n)
        else $error("Call while busy was not ignored.");

    a_irq_flag: assert property (@(posedge clock) disable iff (!resetn)
        s_done_irq |=> s_irq_out)
        else $error("Completion interrupt without occurred flag or disarm.");

    a_irq_enable: assert property (@(posedge clock) disable iff (!resetn)
        $rose(host_irq) |-> $past(w2[dcld_pkg::W2_IE]) && $past(s_r.armed))
        else $error("Host interrupt without enable bit and arming.");

    a_irq_level: assert property (@(posedge clock) disable iff (!resetn)
        host_irq |-> host_irq_level == $past(irq_level_sel))
        else $error("Host interrupt level does not follow the selection.");

    a_chain_stop: assert property (@(posedge clock) disable iff (!resetn)
        status_wr && status_w0[dcld_pkg::W0_ERR] |-> !chain_go)
        else $error("Chain continued after an error.");

    a_param_skip: assert property (@(posedge clock) disable iff (!resetn)
        s_r.st == dcld_pkg::S_CHECK && w5[dcld_pkg::W_ALIGN] |-> !dec_valid [*8])
        else $error("Odd byte count started a transfer.");

    a_err_locator: assert property (@(posedge clock) disable iff (!resetn)
        status_wr && status_w1[dcld_pkg::W1_PARAM] |-> status_w0[dcld_pkg::W0_EXT]
            && status_w0[dcld_pkg::W0_ERR])
        else $error("Error locator bit does not point at word 1.");

    a_track_range: assert property (@(posedge clock) disable iff (!resetn)
        dec_valid |-> dec_track <= 7'h4c && dec_sector < ns)
        else $error("Decoded address outside the supported geometry.");

    a_arm_edge: assert property (@(posedge clock) disable iff (!resetn)
        ie_rise |=> s_r.armed)
        else $error("Enable rising edge did not arm completion interrupts.");
endmodule
`default_nettype wire

/* sim/dcld_ctl_model.sv */
// Controller-side model that answers each decoded transfer after a set delay.
`timescale 1ns/100ps
`default_nettype none
module dcld_ctl_model (
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Decoder side.
    input wire logic dec_valid,
    output logic op_done,
    output logic op_error,
    // Bench control.
    input wire logic [7:0] delay,
    input wire logic fail
);
    logic [8:0] cnt;

    // The error line only means something with the done pulse, so it toggles
    // in between; a design that samples it at the wrong moment sees garbage.
    always @(posedge clock) begin
        op_done <= 1'b0;
        op_error <= ~op_error;
        if (!resetn) begin
            cnt <= 9'h000;
            op_error <= 1'b0;
        end else if (dec_valid) begin
            cnt <= {1'b0, delay} + 9'h001;
        end else if (cnt == 9'h001) begin
            op_done <= 1'b1;
            op_error <= fail;
            cnt <= 9'h000;
        end else if (cnt != 9'h000) begin
            cnt <= cnt - 9'h001;
        end
    end
endmodule
`default_nettype wire

/* sim/disk_command_list_decoder_tb.sv */
// Self-checking bench for the command block decoder.
`timescale 1ns/100ps
`default_nettype none
module disk_command_list_decoder_tb;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic blk_wr = 1'b0;
    logic [3:0] blk_idx = 4'h0;
    logic [15:0] blk_data = 16'h0000;
    logic blk_start = 1'b0;
    logic boot_load = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic cfg_two_sides = 1'b0;
    logic cfg_sec26 = 1'b1;
    logic [1:0] cfg_bps_sel = 2'h0;
    logic [3:0] irq_level_sel = 4'h5;
    logic host_call_bit = 1'b0;
    logic irq_enable_bit = 1'b0;
    logic [7:0] delay = 8'h02;
    logic fail = 1'b0;
    logic op_done, op_error, call_n, busy, dec_valid, dec_head, mem_cmd;
    logic status_wr, host_irq, chain_go, link_is_status;
    logic [6:0] dec_track;
    logic [4:0] dec_sector;
    logic [15:0] dec_count, status_w0, status_w1;
    logic [19:0] dec_data_addr, link_addr;
    logic [3:0] host_irq_level;
    logic v_seen, s_seen, irq_seen, chain_seen;
    int calls = 0;
    int num_errors = 0;
    int checked = 0;

    dcld_decoder u_dcld_decoder (.clock(clock), .resetn(resetn), .blk_wr(blk_wr),
        .blk_idx(blk_idx), .blk_data(blk_data), .blk_start(blk_start),
        .boot_load(boot_load), .cmd_code(cmd_code), .cfg_two_sides(cfg_two_sides),
        .cfg_sec26(cfg_sec26), .cfg_bps_sel(cfg_bps_sel), .irq_level_sel(irq_level_sel),
        .host_call_bit(host_call_bit), .irq_enable_bit(irq_enable_bit),
        .controller_call_irq_n(call_n), .busy(busy), .op_done(op_done),
        .op_error(op_error), .dec_valid(dec_valid), .dec_track(dec_track),
        .dec_head(dec_head), .dec_sector(dec_sector), .dec_count(dec_count),
        .dec_data_addr(dec_data_addr), .mem_cmd(mem_cmd), .status_wr(status_wr),
        .status_w0(status_w0), .status_w1(status_w1), .host_irq(host_irq),
        .host_irq_level(host_irq_level), .chain_go(chain_go), .link_addr(link_addr),
        .link_is_status(link_is_status));

    dcld_ctl_model u_dcld_ctl_model (.clock(clock), .resetn(resetn),
        .dec_valid(dec_valid), .op_done(op_done), .op_error(op_error),
        .delay(delay), .fail(fail));

    // Clock at 100 MHz.
    always #5 clock = ~clock;

    // Pulses are gathered here so that a stray one between checks is not lost.
    always @(posedge clock) begin
        if (dec_valid === 1'b1) v_seen <= 1'b1;
        if (status_wr === 1'b1) s_seen <= 1'b1;
        if (host_irq === 1'b1) irq_seen <= 1'b1;
        if (chain_go === 1'b1) chain_seen <= 1'b1;
        if (call_n === 1'b0) calls <= calls + 1;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Loads words 2 to 9 one per edge, then starts the decode.
    task automatic run(input logic [15:0] w2, w3, w4, w5, w6, w7, w8, w9,
        input logic bt);
        logic [15:0] w [8];
        w = '{w2, w3, w4, w5, w6, w7, w8, w9};
        for (int i = 0; i < 8; i++) begin
            blk_wr <= 1'b1;
            blk_idx <= 4'(i + 2);
            blk_data <= w[i];
            @(posedge clock);
        end
        blk_wr <= 1'b0;
        boot_load <= bt;
        blk_start <= 1'b1;
        {v_seen, s_seen, irq_seen, chain_seen} = 4'h0;
        @(posedge clock);
        blk_start <= 1'b0;
    endtask

    // Waits for the completion under a bound, then judges the pulses seen.
    task automatic done(input logic ev, input logic ei, input logic ec);
        int n;
        n = 0;
        while (s_seen !== 1'b1 && n < 900) begin
            @(posedge clock);
            n++;
        end
        cyc(3);
        chk("status_wr", 1'b1, s_seen);
        chk("dec_valid", ev, v_seen);
        chk("host_irq", ei, irq_seen);
        chk("chain_go", ec, chain_seen);
    endtask

    // The pin passes two sync flops, so each level is held for five edges.
    task automatic arm();
        irq_enable_bit <= 1'b0;
        cyc(5);
        irq_enable_bit <= 1'b1;
        cyc(5);
    endtask

    task automatic call(input int exp);
        int c0;
        c0 = calls;
        host_call_bit <= 1'b1;
        cyc(8);
        host_call_bit <= 1'b0;
        cyc(5);
        chk("call pulses", exp, calls - c0);
    endtask

    task automatic geo(input logic s2, input logic [1:0] b);
        cfg_two_sides <= s2;
        cfg_bps_sel <= b;
        cyc(1);
    endtask

    // Cuts a hung run short well after the tests should have ended.
    initial begin
        #200000;
        num_errors++;
        complete_run();
    end

    // Reset leaves the default level, and an idle call is taken.
    task automatic t_reset();
        chk("level reset", 4'h2, host_irq_level);
        call(1);
    endtask

    // Linear single-sided block; the firing disarms, so the next one stays quiet.
    task automatic t_linear();
        arm();
        run(16'h0080, 16'h0000, 16'h8380, 16'h0100, 16'h000a, 16'h1234, 16'h0000,
            16'h0000, 1'b0);
        done(1'b1, 1'b1, 1'b0);
        chk("track", 7'h0a, dec_track);
        chk("head", 1'b0, dec_head);
        chk("sector", 5'h03, dec_sector);
        chk("count", 16'h0100, dec_count);
        chk("data addr", 20'ha1234, dec_data_addr);
        chk("irq bit", 1'b1, status_w0[dcld_pkg::W0_IRQ]);
        chk("level", 4'h5, host_irq_level);
        run(16'h0080, 16'h0000, 16'h8380, 16'h0100, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
        done(1'b1, 1'b0, 1'b0);
        chk("irq bit off", 1'b0, status_w0[dcld_pkg::W0_IRQ]);
    endtask

    // Double-sided 288-byte linear block that chains on.
    task automatic t_chain();
        arm();
        geo(1'b1, 2'h2);
        run(16'h0000, 16'h0002, 16'hf1c0, 16'h0240, 16'h0, 16'h0, 16'h8003, 16'h4000,
            1'b0);
        done(1'b1, 1'b0, 1'b1);
        chk("track 2", 7'h0c, dec_track);
        chk("head 2", 1'b1, dec_head);
        chk("sector 2", 5'h14, dec_sector);
        chk("link", 20'h34000, link_addr);
        chk("link status", 1'b0, link_is_status);
    endtask

    // Explicit blocks in both sector numbering bases.
    task automatic t_explicit();
        run(16'h0000, 16'h8105, 16'h0000, 16'h0120, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
        done(1'b1, 1'b0, 1'b0);
        chk("x track", 7'h05, dec_track);
        chk("x head", 1'b1, dec_head);
        chk("x sector 288", 5'h00, dec_sector);
        geo(1'b0, 2'h0);
        run(16'h0000, 16'h8007, 16'h0001, 16'h0080, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
        done(1'b1, 1'b0, 1'b0);
        chk("x sector 128", 5'h00, dec_sector);
    endtask

    // Memory command with the recommended address, then a code just past the range.
    task automatic t_mem();
        cmd_code <= 8'h06;
        run(16'h0000, 16'h0000, 16'hfc00, 16'h0080, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
        chk("mem cmd", 1'b1, mem_cmd);
        done(1'b1, 1'b0, 1'b0);
        chk("mem track", 7'h13, dec_track);
        chk("mem sector", 5'h0a, dec_sector);
        cmd_code <= 8'h09;
    endtask

    // Misaligned address in a chain, then an odd count.
    task automatic t_param();
        run(16'h0080, 16'h0000, 16'h0081, 16'h0080, 16'h0, 16'h0, 16'h8001, 16'h0100,
            1'b0);
        chk("not mem cmd", 1'b0, mem_cmd);
        done(1'b0, 1'b1, 1'b0);
        chk("err flag", 1'b1, status_w0[dcld_pkg::W0_ERR]);
        chk("locator", 1'b1, status_w0[dcld_pkg::W0_EXT]);
        chk("param bit", 1'b1, status_w1[dcld_pkg::W1_PARAM]);
        arm();
        run(16'h0080, 16'h0000, 16'h0080, 16'h0081, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
        done(1'b0, 1'b1, 1'b0);
    endtask

    // A failed transfer ends the chain.
    task automatic t_op_error();
        fail <= 1'b1;
        run(16'h0000, 16'h0000, 16'h0100, 16'h0080, 16'h0, 16'h0, 16'h8001, 16'h0200,
            1'b0);
        done(1'b1, 1'b0, 1'b0);
        chk("op err flag", 1'b1, status_w0[dcld_pkg::W0_ERR]);
        fail <= 1'b0;
    endtask

    // A load block returns its status address and never chains.
    task automatic t_boot();
        run(16'h0000, 16'h0000, 16'h0000, 16'h0080, 16'h0, 16'h0, 16'h8002, 16'h0400,
            1'b1);
        done(1'b1, 1'b0, 1'b0);
        chk("boot status", 1'b1, link_is_status);
        chk("boot addr", 20'h20400, link_addr);
    endtask

    // A call while the block is still being decoded is dropped; one after it is taken.
    task automatic t_busy();
        delay <= 8'h64;
        run(16'h0000, 16'h0000, 16'h0080, 16'h0080, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
        call(0);
        chk("busy", 1'b1, busy);
        done(1'b1, 1'b0, 1'b0);
        delay <= 8'h02;
        call(1);
    endtask

    // Main sequence: reset, then every scenario in turn.
    initial begin
        cyc(5);
        resetn <= 1'b1;
        cyc(1);
        t_reset();
        t_linear();
        t_chain();
        t_explicit();
        t_mem();
        t_param();
        t_op_error();
        t_boot();
        t_busy();
        complete_run();
    end
endmodule
`default_nettype wire
